/* common/ccs_pkg.sv */
// Shared constants and types for the charger control sequencer.
`default_nettype none
package ccs_pkg;
  // ----------------------------------------
  // Clock and timing
  // ----------------------------------------
  localparam int unsigned CLK_HZ        = 40000000;
  localparam int unsigned DET_US        = 250000;
  localparam int unsigned DET_CYC       = DET_US * (CLK_HZ / 1000000);
  localparam int unsigned SLEEP_MS      = 20;
  localparam int unsigned SLEEP_CYC     = SLEEP_MS * (CLK_HZ / 1000);
  localparam int unsigned FLASH_HZ      = 2;
  localparam int unsigned FLASH_HALF    = CLK_HZ / (2 * FLASH_HZ);
  localparam int unsigned PRE_TICKS_DEF = 1800;
  localparam int unsigned PRE_TICKS_RES = 900;
  localparam int unsigned FAST_MULT     = 10;
  localparam int unsigned TICK_CYC      = CLK_HZ;
  localparam int unsigned FILT_LEN      = 4;
  localparam int unsigned NUM_CMP       = 12;
  // ----------------------------------------
  // Comparator input positions
  // ----------------------------------------
  localparam int unsigned CMP_RCH   = 0;
  localparam int unsigned CMP_LOWV  = 1;
  localparam int unsigned CMP_TERM  = 2;
  localparam int unsigned CMP_INPUT_GOOD_N = 3;
  localparam int unsigned CMP_OVP   = 4;
  localparam int unsigned CMP_UVLO  = 5;
  localparam int unsigned CMP_TREG  = 6;
  localparam int unsigned CMP_TOFF  = 7;
  localparam int unsigned CMP_TSOK  = 8;
  localparam int unsigned CMP_PPATH = 9;
  localparam int unsigned CMP_VLOW  = 10;
  localparam int unsigned CMP_SUSP  = 11;
  // ----------------------------------------
  // Timer programming pin states
  // ----------------------------------------
  localparam logic [1:0] TMR_OPEN = 2'h0;
  localparam logic [1:0] TMR_GND  = 2'h1;
  localparam logic [1:0] TMR_RES  = 2'h2;
  // ----------------------------------------
  // Sequencer states
  // ----------------------------------------
  typedef enum logic [2:0] {
    CCS_IDLE, CCS_PRE, CCS_FAST, CCS_DONE, CCS_DET_SINK, CCS_DET_PRE,
    CCS_FAULT
  } ccs_state_t;
endpackage
`default_nettype wire

/* rtl/ccs_filter.sv */
// Two-flop synchroniser followed by a stability filter for one input.
`default_nettype none
module ccs_filter #(
  parameter int unsigned LEN = 4
) (
  input  wire logic clk_sys,
  input  wire logic sys_rst,
  input  wire logic raw_in,
  output logic      clean_q
);
  logic                   meta_q;
  logic                   sync_q;
  logic [$clog2(LEN+1):0] cnt_q;
  logic                   differs;

  assign differs = (sync_q != clean_q);

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      meta_q  <= 1'b0;
      sync_q  <= 1'b0;
      cnt_q   <= '0;
      clean_q <= 1'b0;
    end else begin
      meta_q <= raw_in;
      sync_q <= meta_q;
      if (!differs) begin
        cnt_q <= '0;
      end else if (cnt_q == ($clog2(LEN+1)+1)'(LEN - 1)) begin
        cnt_q   <= '0;
        clean_q <= sync_q;
      end else begin
        cnt_q <= cnt_q + 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

/* rtl/ccs_sequencer.sv */
// Charge sequencer: detection, safety timers, faults and status pins.
//
// What this block does
// - After done, recharge threshold starts battery detection.
// - Detection sinks current; battery above low starts charge.
// - Else pre-charge interval; below recharge charges, else retry.
// - Disconnect input high turns battery FET off.
// - Disconnect input high holds charge status low.
// - Separate pre and fast timers; fast is ten times.
// - Open timer pin defaults; grounded pin disables timers.
// - Thermal shutdown freezes both safety timers.
// - Fast timer slows with any charge-current reduction.
// - Pre-charge timer expiry below low threshold faults.
// - Fast timer expiry before termination current faults.
// - Timer fault flashes charge status near two hertz.
// - Fault clears on enable, power, suspend or overvoltage.
// - Input good low only inside headroom-to-overvoltage window.
// - Status low for first cycle; refresh charges float.
// - Thermal pause keeps low; done, disabled, absent float.
// - Die regulation reduces current; shutdown swaps FETs.
// - Thermal regulation suppresses termination detection.
// - Pack temperature outside window suspends charge and timers.
// - Pack temperature suspension keeps status low.
// - Charger stays on twenty milliseconds after sleep entry.
// - Sleep over twenty milliseconds disables input path.
// - Pre-charge until low threshold, then fast charge.
`default_nettype none
module ccs_sequencer #(
  parameter int unsigned DET_CYC    = ccs_pkg::DET_CYC,
  parameter int unsigned SLEEP_CYC  = ccs_pkg::SLEEP_CYC,
  parameter int unsigned FLASH_HALF = ccs_pkg::FLASH_HALF,
  parameter int unsigned TICK_CYC   = ccs_pkg::TICK_CYC,
  parameter int unsigned PRE_DEF    = ccs_pkg::PRE_TICKS_DEF,
  parameter int unsigned PRE_RES    = ccs_pkg::PRE_TICKS_RES
) (
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  input  wire logic        charge_enable_n,
  input  wire logic        battery_disconnect_in,
  input  wire logic [1:0]  timer_program_pin,
  input  wire logic [7:0]  charge_current_ratio,
  input  wire logic [11:0] cmp_raw,
  output logic             charge_status_n_oe,
  output logic             input_good_n_oe,
  output logic             input_fet_on,
  output logic             battery_fet_on,
  output logic             detect_sink_on,
  output logic             precharge_on,
  output logic             fastcharge_on,
  output logic             current_reduce,
  output logic             timer_fault
);
  // ----------------------------------------
  // Comparator conditioning
  // ----------------------------------------
  logic [11:0] cmp;
  genvar gi;
  generate
    for (gi = 0; gi < ccs_pkg::NUM_CMP; gi++) begin : g_filt
      ccs_filter #(.LEN(ccs_pkg::FILT_LEN)) u_filt (
        .clk_sys (clk_sys),
        .sys_rst (sys_rst),
        .raw_in  (cmp_raw[gi]),
        .clean_q (cmp[gi])
      );
    end
  endgenerate

  logic ce_m_q, ce_q, off_m_q, off_q;
  logic [1:0] tmr_m_q, tmr_q;
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      ce_m_q  <= 1'b1;
      ce_q    <= 1'b1;
      off_m_q <= 1'b0;
      off_q   <= 1'b0;
      tmr_m_q <= ccs_pkg::TMR_OPEN;
      tmr_q   <= ccs_pkg::TMR_OPEN;
    end else begin
      ce_m_q  <= charge_enable_n;
      ce_q    <= ce_m_q;
      off_m_q <= battery_disconnect_in;
      off_q   <= off_m_q;
      tmr_m_q <= timer_program_pin;
      tmr_q   <= tmr_m_q;
    end
  end

  wire above_rch  = cmp[ccs_pkg::CMP_RCH];
  wire above_lowv = cmp[ccs_pkg::CMP_LOWV];
  wire at_term    = cmp[ccs_pkg::CMP_TERM];
  wire in_ok      = cmp[ccs_pkg::CMP_INPUT_GOOD_N];
  wire ovp        = cmp[ccs_pkg::CMP_OVP];
  wire uvlo_ok    = cmp[ccs_pkg::CMP_UVLO];
  wire treg       = cmp[ccs_pkg::CMP_TREG];
  wire toff       = cmp[ccs_pkg::CMP_TOFF];
  wire ts_ok      = cmp[ccs_pkg::CMP_TSOK];
  wire ppath      = cmp[ccs_pkg::CMP_PPATH];
  wire vlow       = cmp[ccs_pkg::CMP_VLOW];
  wire usb_susp   = cmp[ccs_pkg::CMP_SUSP];

  // ----------------------------------------
  // Input qualification and sleep hold-off
  // ----------------------------------------
  logic [$clog2(SLEEP_CYC+1)-1:0] sleep_cnt_q;
  logic in_path_q;
  wire  sleep_cond = uvlo_ok && !in_ok && !ovp;
  wire  sleep_long = (sleep_cnt_q == ($bits(sleep_cnt_q))'(SLEEP_CYC));
  // Charger keeps running through short sleep dips from half-wave sources.
  wire  power_ok   = (in_ok && !ovp) || (sleep_cond && !sleep_long);
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      sleep_cnt_q <= '0;
    end else if (!sleep_cond) begin
      sleep_cnt_q <= '0;
    end else if (!sleep_long) begin
      sleep_cnt_q <= sleep_cnt_q + 1'b1;
    end
  end

  // ----------------------------------------
  // Fault clearing events
  // ----------------------------------------
  logic ce_prev_q, pwr_prev_q, susp_prev_q, ovp_prev_q;
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      ce_prev_q   <= 1'b1;
      pwr_prev_q  <= 1'b0;
      susp_prev_q <= 1'b0;
      ovp_prev_q  <= 1'b0;
    end else begin
      ce_prev_q   <= ce_q;
      pwr_prev_q  <= uvlo_ok;
      susp_prev_q <= usb_susp;
      ovp_prev_q  <= ovp;
    end
  end
  wire ce_fall   = ce_prev_q && !ce_q;
  wire ovp_exit  = ovp_prev_q && !ovp;
  wire clr_event = (ce_q != ce_prev_q) || (uvlo_ok != pwr_prev_q) ||
                   (usb_susp != susp_prev_q) || (ovp && !ovp_prev_q);
  wire run_ok    = !ce_q && power_ok && !usb_susp;

  // ----------------------------------------
  // Rate-scaled safety timers
  // ----------------------------------------
  // Forty bits keep the full-rate threshold from wrapping at a 1 s tick.
  localparam logic [39:0] TICK_THR = 40'(TICK_CYC) * 40'h00000000FF;
  logic [39:0] tick_acc_q;
  logic [15:0] tmr_cnt_q;
  ccs_pkg::ccs_state_t st_q, st_d;
  wire timers_off = (tmr_q == ccs_pkg::TMR_GND);
  wire [15:0] pre_lim = (tmr_q == ccs_pkg::TMR_RES) ?
                        16'(PRE_RES) : 16'(PRE_DEF);
  wire [15:0] fast_lim = 16'(pre_lim * ccs_pkg::FAST_MULT);
  // Thermal shutdown and pack temperature freeze counts but keep them.
  wire hold    = toff || !ts_ok;
  wire reduced = ppath || vlow || treg;
  wire [7:0] rate = (st_q == ccs_pkg::CCS_FAST && reduced) ?
                    charge_current_ratio : 8'hFF;
  wire [39:0] acc_sum = tick_acc_q + {32'h00000000, rate};
  wire tick = (acc_sum >= TICK_THR);
  wire [15:0] lim = (st_q == ccs_pkg::CCS_FAST) ? fast_lim : pre_lim;
  wire expired = !timers_off && (tmr_cnt_q >= lim);
  wire timed = (st_q == ccs_pkg::CCS_PRE) || (st_q == ccs_pkg::CCS_FAST);
  always_ff @(posedge clk_sys) begin
    if (sys_rst || st_q != st_d || !timed) begin
      tick_acc_q <= 40'h0000000000;
      tmr_cnt_q  <= 16'h0000;
    end else if (!hold && !timers_off) begin
      tick_acc_q <= tick ? acc_sum - TICK_THR : acc_sum;
      if (tick) begin
        tmr_cnt_q <= tmr_cnt_q + 16'h0001;
      end
    end
  end

  // ----------------------------------------
  // Charge sequence
  // ----------------------------------------
  logic [$clog2(DET_CYC+1)-1:0] det_cnt_q;
  logic first_q, first_d;
  wire det_done = (det_cnt_q == ($bits(det_cnt_q))'(DET_CYC - 1));
  // Termination is ignored while any loop is pulling current down.
  wire term_ok = at_term && !treg && !ppath && !vlow;
  always_comb begin
    st_d    = st_q;
    first_d = first_q;
    if (ce_fall || ovp_exit) begin
      first_d = 1'b1;
    end
    if (!run_ok) begin
      st_d = (st_q == ccs_pkg::CCS_FAULT) ? st_q : ccs_pkg::CCS_IDLE;
    end else begin
      case (st_q)
        ccs_pkg::CCS_IDLE: st_d = above_lowv ? ccs_pkg::CCS_FAST :
                                  ccs_pkg::CCS_PRE;
        ccs_pkg::CCS_PRE: begin
          if (above_lowv) begin
            st_d = ccs_pkg::CCS_FAST;
          end else if (expired) begin
            st_d = ccs_pkg::CCS_FAULT;
          end
        end
        ccs_pkg::CCS_FAST: begin
          if (term_ok && !hold) begin
            st_d    = ccs_pkg::CCS_DONE;
            first_d = 1'b0;
          end else if (expired) begin
            st_d = ccs_pkg::CCS_FAULT;
          end
        end
        ccs_pkg::CCS_DONE: if (!above_rch) begin
          st_d = ccs_pkg::CCS_DET_SINK;
        end
        ccs_pkg::CCS_DET_SINK: if (det_done) begin
          st_d = above_lowv ? ccs_pkg::CCS_IDLE :
                 ccs_pkg::CCS_DET_PRE;
        end
        ccs_pkg::CCS_DET_PRE: if (det_done) begin
          st_d = above_rch ? ccs_pkg::CCS_DET_SINK :
                 ccs_pkg::CCS_IDLE;
        end
        default: st_d = st_q;
      endcase
    end
    if (st_q == ccs_pkg::CCS_FAULT && clr_event) begin
      st_d = ccs_pkg::CCS_IDLE;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      st_q      <= ccs_pkg::CCS_IDLE;
      first_q   <= 1'b1;
      det_cnt_q <= '0;
    end else begin
      st_q    <= st_d;
      first_q <= first_d;
      det_cnt_q <= (st_q != st_d || det_done) ? '0 : det_cnt_q + 1'b1;
    end
  end

  // ----------------------------------------
  // Fault flasher
  // ----------------------------------------
  logic [$clog2(FLASH_HALF+1)-1:0] fl_cnt_q;
  logic fl_q;
  wire fl_wrap = (fl_cnt_q == ($bits(fl_cnt_q))'(FLASH_HALF - 1));
  always_ff @(posedge clk_sys) begin
    if (sys_rst || st_q != ccs_pkg::CCS_FAULT) begin
      fl_cnt_q <= '0;
      fl_q     <= 1'b1;
    end else begin
      fl_cnt_q <= fl_wrap ? '0 : fl_cnt_q + 1'b1;
      fl_q     <= fl_wrap ? !fl_q : fl_q;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  wire charging = (st_q == ccs_pkg::CCS_PRE || st_q == ccs_pkg::CCS_FAST);
  wire chg_low  = off_q ||
                  (st_q == ccs_pkg::CCS_FAULT ? fl_q :
                   (charging && first_q && run_ok));
  wire active = run_ok && !hold;
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      charge_status_n_oe <= 1'b0;
      input_good_n_oe    <= 1'b0;
      input_fet_on       <= 1'b0;
      battery_fet_on     <= 1'b1;
      detect_sink_on     <= 1'b0;
      precharge_on       <= 1'b0;
      fastcharge_on      <= 1'b0;
      current_reduce     <= 1'b0;
      timer_fault        <= 1'b0;
    end else begin
      charge_status_n_oe <= chg_low;
      input_good_n_oe    <= in_ok && !ovp;
      input_fet_on       <= !toff && power_ok;
      battery_fet_on     <= !off_q;
      detect_sink_on     <= run_ok && st_q == ccs_pkg::CCS_DET_SINK;
      precharge_on       <= active && (st_q == ccs_pkg::CCS_PRE ||
                            st_q == ccs_pkg::CCS_DET_PRE);
      fastcharge_on      <= active && st_q == ccs_pkg::CCS_FAST;
      current_reduce     <= treg;
      timer_fault        <= st_q == ccs_pkg::CCS_FAULT;
    end
  end
endmodule
`default_nettype wire

/* verif/ccs_host_model.sv */
// Host side: charge enable driver and pulled-up status lines.
`default_nettype none
module ccs_host_model (
  input  wire logic clk_sys,
  input  wire logic want_charge,
  input  wire logic charge_status_n_oe,
  input  wire logic input_good_n_oe,
  output logic      charge_enable_n,
  output logic      status_pin,
  output logic      good_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  initial charge_enable_n = 1'b1;
  always @(negedge clk_sys) charge_enable_n <= !want_charge;
  // Pull-ups: a released line reads high, never its last driven value.
  assign status_pin = charge_status_n_oe ? 1'b0 : 1'b1;
  assign good_pin   = input_good_n_oe ? 1'b0 : 1'b1;
endmodule
`default_nettype wire

/* verif/ccs_sequencer_properties.sv */
// Port-level concurrent checks for the charge sequencer.
`default_nettype none
module ccs_seq_props #(
  parameter int unsigned FLASH_HALF = 8
) (
  input wire logic        clk_sys,
  input wire logic        sys_rst,
  input wire logic        charge_enable_n,
  input wire logic        battery_disconnect_in,
  input wire logic [1:0]  timer_program_pin,
  input wire logic [7:0]  charge_current_ratio,
  input wire logic [11:0] cmp_raw,
  input wire logic        charge_status_n_oe,
  input wire logic        input_good_n_oe,
  input wire logic        input_fet_on,
  input wire logic        battery_fet_on,
  input wire logic        detect_sink_on,
  input wire logic        precharge_on,
  input wire logic        fastcharge_on,
  input wire logic        current_reduce,
  input wire logic        timer_fault
);
  // ----------------------------------------
  // Flash run length
  // ----------------------------------------
  // A steady status level during a fault means the flash has stalled.
  logic [31:0] run_q;
  logic        last_q;
  always_ff @(posedge clk_sys) begin
    last_q <= charge_status_n_oe;
    if (sys_rst || !timer_fault || battery_disconnect_in ||
        charge_status_n_oe != last_q) begin
      run_q <= 32'h0;
    end else begin
      run_q <= run_q + 32'h1;
    end
  end
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  disc_fet_a: assert property (
    (battery_disconnect_in && !cmp_raw[7])[*8] |-> !battery_fet_on)
    else $error("battery switch on while isolated");
  disc_status_a: assert property (
    battery_disconnect_in[*6] |-> charge_status_n_oe)
    else $error("status released while isolated");
  good_on_a: assert property (
    (cmp_raw[3] && !cmp_raw[4] && cmp_raw[5])[*8] |-> input_good_n_oe)
    else $error("input good not driven in window");
  good_ovp_a: assert property (
    cmp_raw[4][*8] |-> !input_good_n_oe)
    else $error("input good driven in overvoltage");
  one_rate_a: assert property (
    !(precharge_on && fastcharge_on))
    else $error("both charge rates on");
  sink_alone_a: assert property (
    $rose(detect_sink_on) |-> (detect_sink_on && !fastcharge_on)[*8])
    else $error("detection sink cut short");
  shutdown_a: assert property (
    (cmp_raw[7] && !battery_disconnect_in)[*8]
    |-> !input_fet_on && battery_fet_on)
    else $error("switches wrong in shutdown");
  fault_clear_a: assert property (
    timer_fault && (charge_enable_n != $past(charge_enable_n))
    |-> ##[1:10] !timer_fault)
    else $error("fault kept after enable toggle");
  flash_run_a: assert property (
    run_q <= FLASH_HALF + 3)
    else $error("status not flashing in fault");
  fault_cov: cover property (timer_fault);
  sink_cov: cover property (detect_sink_on);
  done_cov: cover property (fastcharge_on ##1 !fastcharge_on);
endmodule
bind ccs_sequencer ccs_seq_props #(.FLASH_HALF(FLASH_HALF)) u_props (
  .clk_sys(clk_sys), .sys_rst(sys_rst), .charge_enable_n(charge_enable_n),
  .battery_disconnect_in(battery_disconnect_in),
  .timer_program_pin(timer_program_pin),
  .charge_current_ratio(charge_current_ratio), .cmp_raw(cmp_raw),
  .charge_status_n_oe(charge_status_n_oe),
  .input_good_n_oe(input_good_n_oe), .input_fet_on(input_fet_on),
  .battery_fet_on(battery_fet_on), .detect_sink_on(detect_sink_on),
  .precharge_on(precharge_on), .fastcharge_on(fastcharge_on),
  .current_reduce(current_reduce), .timer_fault(timer_fault));
`default_nettype wire

/* verif/ccs_sequencer_test.sv */
// Self-checking bench for the charge sequencer.
`default_nettype none
module ccs_sequencer_test;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic [3:0] id; logic v;} ccs_note_t;
  localparam int ST = 0, PG = 1, IFET = 2, BFET = 3;
  localparam int DS = 4, PC = 5, FC = 6, TF = 7;
  logic        clk_sys, sys_rst, bdi, want, st_oe, pg_oe, ifet, bfet;
  logic        dsink, pre, fast, tfault, ce_n, status_pin, good_pin, prev;
  logic        cred;
  logic [1:0]  tmr;
  logic [7:0]  ratio, obs;
  logic [11:0] cmp;
  logic [31:0] seed;
  int          bad_count, n_tests, w, e;
  int          t[2];
  ccs_note_t   q[$];
  event        ev;
  string       nm[8] = '{"status", "good", "in_fet", "bat_fet", "sink",
                         "pre", "fast", "fault"};
  assign obs = {tfault, fast, pre, dsink, bfet, ifet, good_pin, status_pin};
  ccs_sequencer #(.DET_CYC(16), .SLEEP_CYC(20), .FLASH_HALF(8),
    .TICK_CYC(4), .PRE_DEF(4)) uut (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .charge_enable_n(ce_n),
    .battery_disconnect_in(bdi), .timer_program_pin(tmr),
    .charge_current_ratio(ratio), .cmp_raw(cmp),
    .charge_status_n_oe(st_oe), .input_good_n_oe(pg_oe),
    .input_fet_on(ifet), .battery_fet_on(bfet), .detect_sink_on(dsink),
    .precharge_on(pre), .fastcharge_on(fast), .current_reduce(cred),
    .timer_fault(tfault));
  ccs_host_model host (.clk_sys(clk_sys), .want_charge(want),
    .charge_status_n_oe(st_oe), .input_good_n_oe(pg_oe),
    .charge_enable_n(ce_n), .status_pin(status_pin), .good_pin(good_pin));
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = !clk_sys;
  end
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic wrap_up();
    #1;
    $display("checks %0d, mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic chk(input logic s, input logic x, input string n);
    n_tests++;
    if (s !== x) begin
      bad_count++;
      $display("unexpected %s: expected %b, seen %b", n, x, s);
    end
  endtask
  task automatic note(input int id, input logic v);
    q.push_back(ccs_note_t'{id[3:0], v});
    -> ev;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  // Waits are bounded; running out counts as a mismatch and ends the run.
  task automatic wt(input int id, input logic v, input int lim);
    w = 0;
    while (obs[id] !== v) begin
      if (w == lim) begin
        bad_count++;
        $display("unexpected %s: expected %b, seen none", nm[id], v);
        wrap_up();
      end
      cyc(1);
      w++;
    end
    note(id, v);
  endtask
  initial begin
    ccs_note_t n;
    forever begin
      @(ev);
      while (q.size() > 0) begin
        n = q.pop_front();
        chk(obs[n.id], n.v, nm[n.id]);
      end
    end
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    sys_rst = 1'b1;
    bdi = 1'b0;
    want = 1'b0;
    tmr = ccs_pkg::TMR_OPEN;
    ratio = 8'hFF;
    cmp = 12'h000;
    seed = 32'hD3F9;
    bad_count = 0;
    n_tests = 0;
    repeat (8) @(posedge clk_sys);
    cyc(1);
    sys_rst = 1'b0;
    cyc(1);
    note(BFET, 1'b1);
    note(FC, 1'b0);
    cmp = 12'h128;
    cyc(10);
    note(PG, 1'b0);
    cmp[3] = 1'b0;
    cyc(2);
    cmp[3] = 1'b1;
    cyc(8);
    note(PG, 1'b0);
    cmp[4] = 1'b1;
    cyc(10);
    note(PG, 1'b1);
    cmp[4] = 1'b0;
    want = 1'b1;
    wt(PC, 1'b1, 80);
    note(ST, 1'b0);
    cmp[1] = 1'b1;
    wt(FC, 1'b1, 20);
    cmp[8] = 1'b0;
    cyc(12);
    note(FC, 1'b0);
    note(ST, 1'b0);
    cmp[8] = 1'b1;
    wt(FC, 1'b1, 20);
    bdi = 1'b1;
    cyc(10);
    note(BFET, 1'b0);
    note(ST, 1'b0);
    bdi = 1'b0;
    cyc(10);
    note(BFET, 1'b1);
    cmp[7] = 1'b1;
    cyc(10);
    note(IFET, 1'b0);
    cmp[7] = 1'b0;
    wt(IFET, 1'b1, 40);
    cmp = cmp | 12'h045;
    cyc(12);
    note(FC, 1'b1);
    chk(cred, 1'b1, "reduce");
    cmp[6] = 1'b0;
    wt(FC, 1'b0, 20);
    chk(cred, 1'b0, "reduce");
    note(ST, 1'b1);
    cmp = cmp & 12'hFFA;
    wt(DS, 1'b1, 30);
    wt(FC, 1'b1, 60);
    note(ST, 1'b1);
    cmp = cmp | 12'h005;
    wt(FC, 1'b0, 20);
    for (int k = 0; k < 2; k++) begin
      seed = lfsr(seed);
      ratio = (k == 0) ? 8'hFF : {2'b01, seed[5:0]};
      cmp = (k == 0) ? 12'h12A : 12'h32A;
      want = 1'b0;
      cyc(6);
      want = 1'b1;
      wt(FC, 1'b1, 80);
      wt(TF, 1'b1, 1500);
      t[k] = w;
      e = 0;
      prev = status_pin;
      for (int i = 0; i < 40; i++) begin
        cyc(1);
        e += (status_pin !== prev);
        prev = status_pin;
      end
      chk(e >= 3, 1'b1, "flash");
      if (k == 0) begin
        want = 1'b0;
      end else begin
        cmp[11] = 1'b1;
      end
      wt(TF, 1'b0, 12);
    end
    chk(t[1] > t[0] + t[0] / 2, 1'b1, "slowdown");
    cmp = 12'h128;
    want = 1'b0;
    cyc(6);
    want = 1'b1;
    wt(PC, 1'b1, 80);
    wt(TF, 1'b1, 200);
    cmp[4] = 1'b1;
    wt(TF, 1'b0, 20);
    cmp[4] = 1'b0;
    tmr = ccs_pkg::TMR_GND;
    want = 1'b0;
    cyc(6);
    want = 1'b1;
    cyc(300);
    note(TF, 1'b0);
    cmp[3] = 1'b0;
    cyc(12);
    note(IFET, 1'b1);
    note(PG, 1'b1);
    cyc(30);
    note(IFET, 1'b0);
    wrap_up();
  end
endmodule
`default_nettype wire
